// ===== common/svm_pkg.sv
// Function
// - unimplemented register bits always read back as zero
// - bit 6 picks first or second high threshold for the high comparator
// - bits 5:4 pick one of four low thresholds for the low comparator
// - bit 3 connects divider and adc channel when set
// - bit 2 connects divider and enables both comparators when set
// - status register readable anytime, writes ignored
// - status bits 1 and 0 mirror high and low comparator outputs
// - each irq enable bit passes or blocks its change flag request
// - flags readable anytime, write 1 clears, write 0 keeps
// - high change flag sets on any high status change, stays until cleared
// - low change flag sets on any low status change, stays until cleared
// - test registers readable anytime, writable only in special mode
// - stop mode leaves flags untouched; requests only issued in run mode
// - level sense off forces both condition bits to zero
// - disabling sense during active condition sets its change flag
// - one irq is or of flags anded with their enables
// - stop mode opens divider, disables sensing, keeps configuration
package svm_pkg;
   localparam logic [2:0] ADDR_ENABLE = 3'h0;
   localparam logic [2:0] ADDR_STATUS = 3'h1;
   localparam logic [2:0] ADDR_IRQ_EN = 3'h2;
   localparam logic [2:0] ADDR_FLAGS = 3'h3;
   localparam logic [2:0] ADDR_TEST0 = 3'h6;
   localparam logic [2:0] ADDR_TEST1 = 3'h7;
   localparam int BIT_HIGH_SEL = 6;
   localparam int BIT_LOW_SEL_LO = 4;
   localparam int BIT_ADC_EN = 3;
   localparam int BIT_SENSE_EN = 2;
   localparam int BIT_HIGH = 1;
   localparam int BIT_LOW = 0;
   localparam logic [7:0] ENABLE_MASK = 8'h7C;
   localparam logic [7:0] PAIR_MASK = 8'h03;
   localparam logic [7:0] RESET_ENABLE = 8'h00;
   localparam logic [7:0] RESET_IRQ_EN = 8'h00;
   localparam logic [7:0] RESET_TEST = 8'h00;
   localparam logic [1:0] RESET_FLAGS = 2'h0;
endpackage

// ===== src/svm_supply_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module svm_supply_monitor (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic [2:0] bus_addr,
   input wire logic [7:0] bus_wdata,
   input wire logic bus_write,
   input wire logic bus_read,
   output logic [7:0] bus_rdata,
   input wire logic special_mode,
   input wire logic stop_mode,
   input wire logic high_comp_in,
   input wire logic low_comp_in,
   output logic high_level_select,
   output logic [1:0] low_level_select,
   output logic adc_connect,
   output logic level_sense_active,
   output logic divider_closed,
   output logic monitor_irq
);
   // ************************************************************
   // configuration registers
   // ************************************************************
   logic [7:0] enable_q;
   logic [1:0] irq_en_q;
   logic [7:0] test0_q;
   logic [7:0] test1_q;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         enable_q <= svm_pkg::RESET_ENABLE;
      end else if (bus_write && bus_addr == svm_pkg::ADDR_ENABLE) begin
         enable_q <= bus_wdata & svm_pkg::ENABLE_MASK;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         irq_en_q <= svm_pkg::RESET_IRQ_EN[1:0];
      end else if (bus_write && bus_addr == svm_pkg::ADDR_IRQ_EN) begin
         irq_en_q <= bus_wdata[1:0];
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         test0_q <= svm_pkg::RESET_TEST;
         test1_q <= svm_pkg::RESET_TEST;
      end else if (bus_write && special_mode) begin
         if (bus_addr == svm_pkg::ADDR_TEST0) begin
            test0_q <= bus_wdata;
         end
         if (bus_addr == svm_pkg::ADDR_TEST1) begin
            test1_q <= bus_wdata;
         end
      end
   end

   // ************************************************************
   // analog controls
   // ************************************************************
   logic sense_en;
   assign sense_en = enable_q[svm_pkg::BIT_SENSE_EN];

   // stop opens path but enable_q is kept
   assign high_level_select = enable_q[svm_pkg::BIT_HIGH_SEL];
   assign low_level_select =
      enable_q[svm_pkg::BIT_LOW_SEL_LO +: 2];
   assign adc_connect = enable_q[svm_pkg::BIT_ADC_EN] && !stop_mode;
   assign level_sense_active = sense_en && !stop_mode;
   assign divider_closed = adc_connect || level_sense_active;

   // ************************************************************
   // comparator sync and status
   // ************************************************************
   logic [1:0] sync1_q;
   logic [1:0] sync2_q;
   logic [1:0] status_q;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         sync1_q <= 2'h0;
         sync2_q <= 2'h0;
      end else begin
         sync1_q <= {high_comp_in, low_comp_in};
         sync2_q <= sync1_q;
      end
   end

   // stop history; the synchroniser lags comparator wake-up by two edges
   logic [1:0] thaw_q;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         thaw_q <= 2'h0;
      end else begin
         thaw_q <= {thaw_q[0], stop_mode};
      end
   end

   logic [1:0] status_d;
   // forced low when sensing is disabled; held through stop and wake-up
   always_comb begin
      if (!sense_en) begin
         status_d = 2'h0;
      end else if (stop_mode || (|thaw_q)) begin
         status_d = status_q;
      end else begin
         status_d = sync2_q;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         status_q <= 2'h0;
      end else begin
         status_q <= status_d;
      end
   end

   // ************************************************************
   // change flags
   // ************************************************************
   logic [1:0] flags_q;
   logic [1:0] change;
   logic [1:0] clear;

   assign change = status_d ^ status_q;
   assign clear = (bus_write && bus_addr == svm_pkg::ADDR_FLAGS) ?
      bus_wdata[1:0] : 2'h0;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         flags_q <= svm_pkg::RESET_FLAGS;
      end else begin
         // set wins over clear
         flags_q <= (flags_q & ~clear) | change;
      end
   end

   // ************************************************************
   // interrupt request
   // ************************************************************
   assign monitor_irq =
      |(flags_q & irq_en_q) && !stop_mode;

   // ************************************************************
   // read port
   // ************************************************************
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         bus_rdata <= 8'h00;
      end else if (bus_read) begin
         unique case (bus_addr)
            svm_pkg::ADDR_ENABLE: bus_rdata <= enable_q;
            svm_pkg::ADDR_STATUS: bus_rdata <= {6'h00, status_q};
            svm_pkg::ADDR_IRQ_EN: bus_rdata <= {6'h00, irq_en_q};
            svm_pkg::ADDR_FLAGS: bus_rdata <= {6'h00, flags_q};
            svm_pkg::ADDR_TEST0: bus_rdata <= test0_q;
            svm_pkg::ADDR_TEST1: bus_rdata <= test1_q;
            default: bus_rdata <= 8'h00;
         endcase
      end else begin
         bus_rdata <= 8'h00;
      end
   end
endmodule
`default_nettype wire

// ===== verification/svm_comp_model.sv
`timescale 1ns/10ps
`default_nettype none
module svm_comp_model (
   input wire logic above_high,
   input wire logic below_low,
   input wire logic level_sense_active,
   output logic high_comp_in,
   output logic low_comp_in
);
   // unpowered comparators read low
   assign high_comp_in = above_high & level_sense_active;
   assign low_comp_in = below_low & level_sense_active;
endmodule
`default_nettype wire

// ===== verification/svm_properties.sv
`timescale 1ns/10ps
`default_nettype none
module svm_properties (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic [2:0] bus_addr,
   input wire logic [7:0] bus_wdata,
   input wire logic bus_write,
   input wire logic bus_read,
   input wire logic [7:0] bus_rdata,
   input wire logic stop_mode,
   input wire logic high_level_select,
   input wire logic [1:0] low_level_select,
   input wire logic adc_connect,
   input wire logic level_sense_active,
   input wire logic divider_closed,
   input wire logic monitor_irq
);
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   a_high_select: assert property (bus_write && bus_addr == 0
      |=> high_level_select == $past(bus_wdata[6])) else $error("hsel");
   a_low_select: assert property (bus_write && bus_addr == 0
      |=> low_level_select == $past(bus_wdata[5:4])) else $error("lsel");
   a_adc_link: assert property (bus_write && bus_addr == 0
      && bus_wdata[3] ##1 !stop_mode |-> adc_connect) else $error("adc");
   a_sense_path: assert property (level_sense_active |-> divider_closed)
      else $error("divider");
   a_stop_path: assert property (stop_mode |-> !divider_closed)
      else $error("stop path");
   a_stop_irq: assert property (stop_mode |-> !monitor_irq)
      else $error("stop irq");
   a_irq_mask: assert property (bus_write && bus_addr == 2
      && bus_wdata[1:0] == 0 |=> !monitor_irq) else $error("mask");
   a_idle_rdata: assert property (!bus_read |=> bus_rdata == 0)
      else $error("rdata");
endmodule
bind svm_supply_monitor svm_properties u_props (.*);
`default_nettype wire

// ===== verification/svm_supply_monitor_tb.sv
`timescale 1ns/10ps
`default_nettype none
module svm_supply_monitor_tb;
   logic clock = 0, reset_n = 0, bus_write = 0, bus_read = 0;
   logic special_mode = 0, stop_mode = 0, above_high = 0, below_low = 0;
   logic [2:0] bus_addr = 0;
   logic [7:0] bus_wdata = 0, bus_rdata;
   logic high_comp_in, low_comp_in, high_level_select, adc_connect;
   logic level_sense_active, divider_closed, monitor_irq;
   logic [1:0] low_level_select;
   int n_mismatch = 0, n_checks = 0;
   always #50 clock = ~clock;
   svm_supply_monitor dut (.*);
   svm_comp_model cmp (.*);
   task automatic chk(logic [7:0] got, logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(logic [2:0] a, logic [7:0] d);
      @(posedge clock);
      bus_write <= 1;
      bus_addr <= a;
      bus_wdata <= d;
      @(posedge clock);
      bus_write <= 0;
      #1;
   endtask
   task automatic rd(logic [2:0] a, logic [7:0] e);
      @(posedge clock);
      bus_read <= 1;
      bus_addr <= a;
      @(posedge clock);
      bus_read <= 0;
      #1 chk(bus_rdata, e);
   endtask
   task automatic t_regs;
      for (int a = 0; a < 8; a++) rd(a[2:0], 8'h00);
      wr(0, 8'hFF);
      rd(0, 8'h7C);
      for (int s = 0; s < 8; s++) begin
         wr(0, 8'(s << 4));
         chk(8'({high_level_select, low_level_select}), 8'(s));
      end
      wr(0, 8'h08);
      chk(8'({adc_connect, divider_closed}), 8'h03);
      wr(1, 8'hFF);
      rd(1, 8'h00);
      wr(6, 8'h5A);
      rd(6, 8'h00);
      special_mode <= 1;
      wr(6, 8'h5A);
      rd(6, 8'h5A);
      wr(6, 8'h00);
      special_mode <= 0;
   endtask
   task automatic t_flags;
      wr(0, 8'h04);
      wr(2, 8'h03);
      above_high <= 1;
      repeat (4) @(posedge clock);
      #1 chk(8'(monitor_irq), 8'h01);
      rd(1, 8'h02);
      rd(3, 8'h02);
      wr(3, 8'h01);
      rd(3, 8'h02);
      wr(3, 8'h02);
      rd(3, 8'h00);
      below_low <= 1;
      repeat (4) @(posedge clock);
      rd(3, 8'h01);
      wr(2, 8'h00);
      chk(8'(monitor_irq), 8'h00);
      wr(2, 8'h03);
      stop_mode <= 1;
      rd(3, 8'h01);
      chk(8'(level_sense_active), 8'h00);
      stop_mode <= 0;
      repeat (4) @(posedge clock);
      rd(3, 8'h01);
      wr(3, 8'h03);
      wr(0, 8'h00);
      repeat (4) @(posedge clock);
      rd(1, 8'h00);
      rd(3, 8'h03);
      chk(8'(monitor_irq), 8'h01);
   endtask
   task automatic t_quiet;
      wr(0, 8'h04);
      repeat (6) @(posedge clock);
      wr(3, 8'h03);
      rd(3, 8'h00);
      wr(2, 8'h00);
      wr(0, 8'h00);
      repeat (4) @(posedge clock);
      #1 chk(8'(monitor_irq), 8'h00);
      rd(3, 8'h03);
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clock);
      reset_n <= 1;
      t_regs;
      t_flags;
      t_quiet;
      wrap_up;
   end
   initial begin
      #500us;
      n_mismatch++;
      wrap_up;
   end
endmodule
`default_nettype wire
